// ---- hdl/slr_dev_end.sv ----
`timescale 1ns/1ps
module slr_dev_end (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  slr_reg_if.dev           bus,
  input  wire logic        serial_link_enable_i,
  input  wire logic        link_mode_is_8b10b_i,
  input  wire logic        link_up_i,
  input  wire logic        sync_n_i,
  input  wire logic        sysref_i,
  input  wire logic        sysref_realign_i,
  input  wire logic        serializer_pll_lock_i,
  input  wire logic        converter_pll_lock_i,
  input  wire logic [15:0] sample_data_i,
  output logic [15:0]      lane_word_o,
  output logic [1:0]       lane_k_o,
  output logic             ila_repeat_o,
  output logic             rpat_repeat_o,
  output logic [4:0]       test_pattern_code_o,
  output logic [7:0]       lane_align_device_number_o,
  output logic [7:0]       frame_end_char_o,
  output logic             frame_end_char_en_o,
  output logic [7:0]       link_status_word_o
);
  import slr_pkg::*;

  slr_dev_s    r;
  slr_dev_s    n;
  slr_poly_e   poly;
  logic [15:0] prbs_word;
  logic [7:0]  status;
  logic        take;
  logic        wr;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic hit(input logic [9:0] a,
                               input logic [9:0] reg_a);
    hit = (a == reg_a);
  endfunction

  function automatic logic [7:0] comma_char(input logic [1:0] c);
    case (c)
      CC_K281: comma_char = CH_K281;
      CC_K285: comma_char = CH_K285;
      // reserved code falls back to the compliant comma
      default: comma_char = CH_K287;
    endcase
  endfunction

  // ----------------------------------------------------------
  // live status word
  // ----------------------------------------------------------
  always_comb begin
    status = 8'h00;
    status[ST_LINK_UP] = link_up_i;
    status[ST_SYNC] = sync_n_i;
    status[ST_REALIGN] = r.realigned;
    status[ST_MULTIFRAME_PHASE_SET_FLAG] = r.multiframe_phase_set_flag;
    status[ST_SPLL] = serializer_pll_lock_i;
    status[ST_CPLL] = converter_pll_lock_i;
  end

  // ----------------------------------------------------------
  // prbs selection
  // ----------------------------------------------------------
  always_comb begin
    case (r.test_code)
      TC_PRBS7:  poly = PS_7;
      TC_PRBS9:  poly = PS_9;
      TC_PRBS15: poly = PS_15;
      TC_PRBS23: poly = PS_23;
      default:   poly = PS_31;
    endcase
  end

  // sequence restarts while the link is down so each run is repeatable
  slr_prbs u_prbs (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .sel_i     (poly),
    .restart_i (!serial_link_enable_i),
    .word_o    (prbs_word)
  );

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  assign take = bus.req && !r.ack;
  assign wr = take && bus.we;

  always_comb begin
    n = r;
    n.ack = 1'b0;
    n.en_d = serial_link_enable_i;

    // register access
    if (take) begin
      n.ack = 1'b1;
      if (hit(bus.addr, ADDR_TEST)) begin
        n.rdata = {3'h0, r.test_code};
      end else if (hit(bus.addr, ADDR_DEVNUM)) begin
        n.rdata = r.dev_num;
      end else if (hit(bus.addr, ADDR_COMMA)) begin
        n.rdata = {6'h00, r.comma};
      end else if (hit(bus.addr, ADDR_STATUS)) begin
        n.rdata = status;
      end else begin
        n.rdata = 8'h00;
      end
    end
    if (wr && hit(bus.addr, ADDR_TEST)) begin
      n.test_code = bus.wdata[4:0];
    end
    if (wr && hit(bus.addr, ADDR_DEVNUM)) begin
      n.dev_num = bus.wdata;
    end
    if (wr && hit(bus.addr, ADDR_COMMA)) begin
      n.comma = bus.wdata[1:0];
    end

    // sticky flags: write one clears, a zero leaves them, a set wins
    if (wr && hit(bus.addr, ADDR_STATUS)) begin
      if (bus.wdata[ST_REALIGN]) begin
        n.realigned = 1'b0;
      end
      if (bus.wdata[ST_MULTIFRAME_PHASE_SET_FLAG]) begin
        n.multiframe_phase_set_flag = 1'b0;
      end
    end
    if (sysref_realign_i) begin
      n.realigned = 1'b1;
    end
    if (serial_link_enable_i && !r.en_d) begin
      n.armed = 1'b1;
    end else if (!serial_link_enable_i) begin
      n.armed = 1'b0;
    end
    if (r.armed && serial_link_enable_i && sysref_i) begin
      n.multiframe_phase_set_flag = 1'b1;
      n.armed = 1'b0;
    end

    // frame end comma
    n.eof_char = comma_char(r.comma);
    n.eof_en = link_mode_is_8b10b_i;

    // lane pattern
    n.word = sample_data_i;
    n.k = 2'b00;
    n.ila_rep = 1'b0;
    n.rpat = 1'b0;
    n.ramp = r.ramp;
    n.tl_cnt = r.tl_cnt;
    case (r.test_code)
      TC_PRBS7, TC_PRBS9, TC_PRBS15,
      TC_PRBS23, TC_PRBS31: begin
        n.word = prbs_word;
      end
      TC_RAMP: begin
        n.word = {r.ramp + 8'h01, r.ramp};
        n.ramp = r.ramp + 8'h02;
      end
      TC_TRANS: begin
        n.word = {r.tl_cnt, ~r.tl_cnt};
        n.tl_cnt = r.tl_cnt + 8'h01;
      end
      TC_D215: begin
        n.word = {CH_D215, CH_D215};
      end
      TC_K285: begin
        if (link_mode_is_8b10b_i) begin
          n.word = {CH_K285, CH_K285};
          n.k = 2'b11;
        end
      end
      TC_ILA: begin
        n.ila_rep = link_mode_is_8b10b_i;
      end
      TC_RPAT: begin
        n.rpat = link_mode_is_8b10b_i;
      end
      TC_K287: begin
        if (link_mode_is_8b10b_i) begin
          n.word = {CH_K287, CH_K287};
          n.k = 2'b11;
        end
      end
      TC_LOW: begin
        n.word = 16'h0000;
      end
      TC_HIGH: begin
        n.word = 16'hffff;
      end
      TC_CLOCK: begin
        n.word = CLOCK_WORD;
      end
      default: begin
        // reserved codes behave as normal data
        n.word = sample_data_i;
      end
    endcase
    // counters idle outside their mode so each test starts from zero
    if (r.test_code != TC_RAMP) begin
      n.ramp = 8'h00;
    end
    if (r.test_code != TC_TRANS) begin
      n.tl_cnt = 8'h00;
    end
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.test_code <= RST_TEST[4:0];
      r.dev_num <= RST_DEVNUM;
      r.comma <= RST_COMMA[1:0];
    end else if (ce_i) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign bus.ack = r.ack;
  assign bus.rdata = r.rdata;
  assign lane_word_o = r.word;
  assign lane_k_o = r.k;
  assign ila_repeat_o = r.ila_rep;
  assign rpat_repeat_o = r.rpat;
  assign test_pattern_code_o = r.test_code;
  assign lane_align_device_number_o = r.dev_num;
  assign frame_end_char_o = r.eof_char;
  assign frame_end_char_en_o = r.eof_en;
  assign link_status_word_o = status;
endmodule

// ---- hdl/slr_host_end.sv ----
`timescale 1ns/1ps
module slr_host_end (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  slr_reg_if.host         bus,
  input  wire logic       serial_link_enable_i,
  input  wire logic       rx_is_standard_i,
  input  wire logic       cmd_valid_i,
  input  wire logic       cmd_write_i,
  input  wire logic [9:0] cmd_addr_i,
  input  wire logic [7:0] cmd_wdata_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic            rsp_refused_o,
  output logic [7:0]      rsp_data_o
);
  import slr_pkg::*;

  slr_host_s  r;
  slr_host_s  n;
  logic       cfg_reg;
  logic       bad_code;
  logic       bad_comma;
  logic       refuse;
  logic [7:0] clean;

  // ----------------------------------------------------------
  // write checks
  // ----------------------------------------------------------
  always_comb begin
    cfg_reg = (cmd_addr_i == ADDR_TEST) ||
              (cmd_addr_i == ADDR_DEVNUM) ||
              (cmd_addr_i == ADDR_COMMA);
    bad_code = (cmd_addr_i == ADDR_TEST) &&
               ((cmd_wdata_i[4:0] == TC_RSVD12) ||
                (cmd_wdata_i[4:0] > TC_K287));
    bad_comma = (cmd_addr_i == ADDR_COMMA) &&
                ((cmd_wdata_i[1:0] == 2'h3) ||
                 (rx_is_standard_i && cmd_wdata_i[1:0] != CC_K287));
    refuse = cmd_write_i &&
             ((cfg_reg && serial_link_enable_i) || bad_code || bad_comma);
    if (cmd_addr_i == ADDR_TEST) begin
      clean = {3'h0, cmd_wdata_i[4:0]};
    end else if (cmd_addr_i == ADDR_COMMA) begin
      clean = {6'h00, cmd_wdata_i[1:0]};
    end else begin
      clean = cmd_wdata_i;
    end
  end

  // ----------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------
  always_comb begin
    n = r;
    n.rsp_valid = 1'b0;
    case (r.state)
      HS_IDLE: begin
        if (cmd_valid_i) begin
          if (refuse) begin
            n.rsp_valid = 1'b1;
            n.rsp_refused = 1'b1;
            n.rsp_data = 8'h00;
          end else begin
            n.state = HS_BUSY;
            n.req = 1'b1;
            n.we = cmd_write_i;
            n.addr = cmd_addr_i;
            n.wdata = cmd_write_i ? clean : 8'h00;
          end
        end
      end
      HS_BUSY: begin
        // request held until the device answers
        if (bus.ack) begin
          n.state = HS_IDLE;
          n.req = 1'b0;
          n.rsp_valid = 1'b1;
          n.rsp_refused = 1'b0;
          n.rsp_data = bus.rdata;
        end
      end
      default: begin
        n.state = HS_IDLE;
        n.req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.state <= HS_IDLE;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign cmd_ready_o = (r.state == HS_IDLE);
  assign rsp_valid_o = r.rsp_valid;
  assign rsp_refused_o = r.rsp_refused;
  assign rsp_data_o = r.rsp_data;
  assign bus.req = r.req;
  assign bus.we = r.we;
  assign bus.addr = r.addr;
  assign bus.wdata = r.wdata;
endmodule

// ---- hdl/slr_pkg.sv ----
// What this block does
// - test code resets zero, zero sends samples
// - codes 7,8,9,16 only in 8b10b modes
// - code 10 lanes low, 11 lanes high
// - code 15 sends repeated 0x00ff word
// - test code changed only while link disabled
// - device number goes into ila multiframe two
// - device number, comma changed only while disabled
// - comma 0 k28.7, 1 k28.1, 2 k28.5
// - standard receiver keeps comma code zero
// - status bit 6 shows link up
// - status bit 5 shows sync request level
// - bit 4 sticky on realign, write one clears
// - bit 3 set by first sysref after enable
// - bit 2 serializer lock, bit 0 converter lock
// - software writes zero into reserved bits; host clears them for test and comma writes only
package slr_pkg;

  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [9:0] ADDR_TEST   = 10'h205;
  localparam logic [9:0] ADDR_DEVNUM = 10'h206;
  localparam logic [9:0] ADDR_COMMA  = 10'h207;
  localparam logic [9:0] ADDR_STATUS = 10'h208;

  localparam logic [7:0] RST_TEST   = 8'h00;
  localparam logic [7:0] RST_DEVNUM = 8'h00;
  localparam logic [7:0] RST_COMMA  = 8'h00;

  localparam int ST_LINK_UP  = 6;
  localparam int ST_SYNC     = 5;
  localparam int ST_REALIGN  = 4;
  localparam int ST_MULTIFRAME_PHASE_SET_FLAG  = 3;
  localparam int ST_SPLL     = 2;
  localparam int ST_CPLL     = 0;

  // ----------------------------------------------------------
  // test pattern codes
  // ----------------------------------------------------------
  localparam logic [4:0] TC_NORMAL = 5'h00;
  localparam logic [4:0] TC_PRBS7  = 5'h01;
  localparam logic [4:0] TC_PRBS15 = 5'h02;
  localparam logic [4:0] TC_PRBS23 = 5'h03;
  localparam logic [4:0] TC_RAMP   = 5'h04;
  localparam logic [4:0] TC_TRANS  = 5'h05;
  localparam logic [4:0] TC_D215   = 5'h06;
  localparam logic [4:0] TC_K285   = 5'h07;
  localparam logic [4:0] TC_ILA    = 5'h08;
  localparam logic [4:0] TC_RPAT   = 5'h09;
  localparam logic [4:0] TC_LOW    = 5'h0a;
  localparam logic [4:0] TC_HIGH   = 5'h0b;
  localparam logic [4:0] TC_RSVD12 = 5'h0c;
  localparam logic [4:0] TC_PRBS9  = 5'h0d;
  localparam logic [4:0] TC_PRBS31 = 5'h0e;
  localparam logic [4:0] TC_CLOCK  = 5'h0f;
  localparam logic [4:0] TC_K287   = 5'h10;

  localparam logic [15:0] CLOCK_WORD = 16'h00ff;
  localparam logic [7:0]  CH_D215    = 8'hb5;
  localparam logic [7:0]  CH_K285    = 8'hbc;
  localparam logic [7:0]  CH_K281    = 8'h3c;
  localparam logic [7:0]  CH_K287    = 8'hfc;

  // ----------------------------------------------------------
  // comma codes and prbs selectors
  // ----------------------------------------------------------
  localparam logic [1:0] CC_K287 = 2'h0;
  localparam logic [1:0] CC_K281 = 2'h1;
  localparam logic [1:0] CC_K285 = 2'h2;

  typedef enum logic [2:0] {
    PS_7  = 3'h0,
    PS_9  = 3'h1,
    PS_15 = 3'h2,
    PS_23 = 3'h3,
    PS_31 = 3'h4
  } slr_poly_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_BUSY = 2'b10
  } slr_host_state_e;

  typedef struct packed {
    logic [30:0] lfsr;
    logic [15:0] word;
  } slr_prbs_s;

  typedef struct packed {
    logic [4:0]  test_code;
    logic [7:0]  dev_num;
    logic [1:0]  comma;
    logic        realigned;
    logic        multiframe_phase_set_flag;
    logic        armed;
    logic        en_d;
    logic        ack;
    logic [7:0]  rdata;
    logic [15:0] word;
    logic [1:0]  k;
    logic        ila_rep;
    logic        rpat;
    logic [7:0]  ramp;
    logic [7:0]  tl_cnt;
    logic [7:0]  eof_char;
    logic        eof_en;
  } slr_dev_s;

  typedef struct packed {
    slr_host_state_e state;
    logic            req;
    logic            we;
    logic [9:0]      addr;
    logic [7:0]      wdata;
    logic            rsp_valid;
    logic            rsp_refused;
    logic [7:0]      rsp_data;
  } slr_host_s;

endpackage

// ---- hdl/slr_prbs.sv ----
`timescale 1ns/1ps
module slr_prbs (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire slr_pkg::slr_poly_e sel_i,
  input  wire logic              restart_i,
  output logic [15:0]            word_o
);
  import slr_pkg::*;

  slr_prbs_s r;
  slr_prbs_s n;

  // ----------------------------------------------------------
  // tap decode, shared by both feedback terms
  // ----------------------------------------------------------
  function automatic logic [9:0] taps(input slr_poly_e s);
    case (s)
      PS_7:    taps = {5'd6, 5'd5};
      PS_9:    taps = {5'd8, 5'd4};
      PS_15:   taps = {5'd14, 5'd13};
      PS_23:   taps = {5'd22, 5'd17};
      default: taps = {5'd30, 5'd27};
    endcase
  endfunction

  // ----------------------------------------------------------
  // sixteen serial steps per clock
  // ----------------------------------------------------------
  always_comb begin
    logic [30:0] s;
    logic [9:0]  t;
    logic        fb;
    s = r.lfsr;
    t = taps(sel_i);
    fb = 1'b0;
    n = r;
    for (int i = 15; i >= 0; i--) begin
      fb = s[t[9:5]] ^ s[t[4:0]];
      n.word[i] = fb;
      s = {s[29:0], fb};
    end
    n.lfsr = s;
    // all-ones seed so no polynomial can lock up at zero
    if (restart_i) begin
      n.lfsr = '1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '{lfsr: '1, word: '0};
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign word_o = r.word;
endmodule

// ---- hdl/slr_reg_if.sv ----
`timescale 1ns/1ps
interface slr_reg_if;
  logic       req;
  logic       we;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;

  modport dev  (input req, we, addr, wdata, output rdata, ack);
  modport host (output req, we, addr, wdata, input rdata, ack);
endinterface

// ---- test/slr_checker.sv ----
`timescale 1ns/1ps
module slr_checker
  import slr_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       req,
  input wire logic       we,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------
  // bus handshake, read values and written values
  // ----------------------------------------------------------
  property p_ack_next;
    req && !ack |=> ack;
  endproperty
  property p_req_hold;
    req && !ack |=> req && $stable(addr) && $stable(we);
  endproperty
  property p_ack_end;
    ack |=> !ack && !req;
  endproperty
  property p_test_rd;
    ack && !we && addr == ADDR_TEST |-> rdata[7:5] == 3'h0;
  endproperty
  property p_comma_rd;
    ack && !we && addr == ADDR_COMMA |-> rdata[7:2] == 6'h00 && rdata[1:0] != 2'h3;
  endproperty
  property p_status_rd;
    ack && !we && addr == ADDR_STATUS |-> rdata[7] == 1'b0 && rdata[1] == 1'b0;
  endproperty
  property p_code_wr;
    req && we && addr == ADDR_TEST |-> wdata[4:0] != TC_RSVD12 && wdata[4:0] <= TC_K287 && wdata[7:5] == 3'h0;
  endproperty
  property p_comma_wr;
    req && we && addr == ADDR_COMMA |-> wdata[7:2] == 6'h00 && wdata[1:0] != 2'h3;
  endproperty
  property p_unmapped;
    ack && !we && !(addr inside {[ADDR_TEST:ADDR_STATUS]}) |-> rdata == 8'h00;
  endproperty

  a_ack_next: assert property (p_ack_next)
    else $error("ack not one cycle after request");
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before ack");
  a_ack_end: assert property (p_ack_end)
    else $error("ack or request stood too long");
  a_test_rd: assert property (p_test_rd)
    else $error("test code reserved bits read nonzero");
  a_comma_rd: assert property (p_comma_rd)
    else $error("comma code read reserved value");
  a_status_rd: assert property (p_status_rd)
    else $error("status reserved bits read nonzero");
  a_code_wr: assert property (p_code_wr)
    else $error("reserved test code written");
  a_comma_wr: assert property (p_comma_wr)
    else $error("reserved comma code written");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  c_code_wr: cover property (ack && we && addr == ADDR_TEST);
  c_multiframe_phase_set_flag: cover property (ack && !we && addr == ADDR_STATUS && rdata[3]);
  c_unmapped: cover property (ack && !we && addr > ADDR_STATUS);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import slr_pkg::*;
  logic        ref_clk = 0, rst_n = 0, en = 0, m8 = 1, std = 0, lup = 0, syn = 1;
  logic        sref = 0, realn = 0, spl = 0, cpl = 0, cv = 0, cw = 0, ce = 1;
  logic [31:0] pw;
  logic [9:0]  ca = 0;
  logic [7:0]  cd = 0, rdv, devnum, fe_char, stat, rsp_data, lane_align_device_number = 0;
  logic [15:0] smp = 0, lane_word, w1, w2;
  logic [1:0]  lane_k, cc = 0;
  logic [4:0]  tpc, tc = 0;
  logic        rfv, ila_rep, rpat_rep, fe_en, cmd_ready, rsp_valid, rsp_ref, rl = 0, al = 0;
  int          n_fail = 0, num_checks = 0;
  logic [7:0]  chr [3] = '{CH_K287, CH_K281, CH_K285};
  logic [4:0]  walk [7] = '{TC_RAMP, TC_TRANS, TC_PRBS7, TC_PRBS15, TC_PRBS23, TC_PRBS9, TC_PRBS31};

  always #5 ref_clk = ~ref_clk;

  slr_reg_if bus_if ();
  slr_dev_end u_slr_dev_end (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .bus(bus_if.dev),
    .serial_link_enable_i(en), .link_mode_is_8b10b_i(m8), .link_up_i(lup), .sync_n_i(syn),
    .sysref_i(sref), .sysref_realign_i(realn), .serializer_pll_lock_i(spl), .converter_pll_lock_i(cpl),
    .sample_data_i(smp), .lane_word_o(lane_word), .lane_k_o(lane_k), .ila_repeat_o(ila_rep),
    .rpat_repeat_o(rpat_rep), .test_pattern_code_o(tpc), .lane_align_device_number_o(devnum),
    .frame_end_char_o(fe_char), .frame_end_char_en_o(fe_en), .link_status_word_o(stat));
  slr_host_end u_slr_host_end (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(ce), .bus(bus_if.host),
    .serial_link_enable_i(en), .rx_is_standard_i(std), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_refused_o(rsp_ref), .rsp_data_o(rsp_data));
  slr_checker u_slr_checker (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack));

  // ----------------------------------------------------------
  // checking and host command tasks
  // ----------------------------------------------------------
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // reference sequence: all-ones seed, msb first, first two lane words after enable
  function automatic logic [31:0] prbs_ref(input logic [4:0] c);
    logic [30:0] s;
    logic [31:0] w;
    int          a;
    int          b;
    s = '1;
    w = '0;
    a = 30;
    b = 27;
    case (c)
      TC_PRBS7: begin
        a = 6;
        b = 5;
      end
      TC_PRBS9: begin
        a = 8;
        b = 4;
      end
      TC_PRBS15: begin
        a = 14;
        b = 13;
      end
      TC_PRBS23: begin
        a = 22;
        b = 17;
      end
      default: begin
        a = 30;
        b = 27;
      end
    endcase
    for (int i = 31; i >= 0; i--) begin
      w[i] = s[a] ^ s[b];
      s = {s[29:0], w[i]};
    end
    return w;
  endfunction

  // one command at a time; response waited for under a bound
  task automatic cmd(input logic w, input logic [9:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    cv <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= d;
    @(posedge ref_clk);
    cv <= 1'b0;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (!rsp_valid && i < 8);
    chk(rsp_valid, 1'b1);
    rdv = rsp_data;
    rfv = rsp_ref;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic rf;
    cmd(1'b1, a, d);
    rf = en && a inside {[ADDR_TEST:ADDR_COMMA]} || a == ADDR_TEST && (d[4:0] == TC_RSVD12 ||
         d[4:0] > TC_K287) || a == ADDR_COMMA && (d[1:0] == 2'h3 || std && d[1:0] != CC_K287);
    chk(rfv, rf);
    if (rf) chk(rdv, 8'h00);
    else if (a == ADDR_TEST) tc = d[4:0];
    else if (a == ADDR_DEVNUM) lane_align_device_number = d;
    else if (a == ADDR_COMMA) cc = d[1:0];
    else if (a == ADDR_STATUS) begin
      if (d[4]) rl = 1'b0;
      if (d[3]) al = 1'b0;
    end
  endtask

  task automatic rd(input logic [9:0] a);
    logic [7:0] e;
    cmd(1'b0, a, 8'h00);
    case (a)
      ADDR_TEST:   e = {3'h0, tc};
      ADDR_DEVNUM: e = lane_align_device_number;
      ADDR_COMMA:  e = {6'h00, cc};
      ADDR_STATUS: e = {1'b0, lup, syn, rl, al, spl, 1'b0, cpl};
      default:     e = 8'h00;
    endcase
    chk(rdv, e);
    chk(stat, {1'b0, lup, syn, rl, al, spl, 1'b0, cpl});
  endtask

  task automatic pat(input logic [4:0] c, input logic [15:0] w, input logic [1:0] k);
    wr(ADDR_TEST, {3'h0, c});
    repeat (2) @(negedge ref_clk);
    chk(lane_word, w);
    chk(lane_k, k);
    chk(tpc, tc);
  endtask

  initial begin
    #200_000;
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(32'h3a54));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 5; a++) rd(ADDR_TEST + 10'(a));
    repeat (3) begin
      @(posedge ref_clk);
      {lup, syn, spl, cpl} <= 4'($urandom);
      smp <= 16'($urandom);
      rd(ADDR_STATUS);
    end
    pat(TC_NORMAL, smp, 2'b00);
    pat(TC_LOW, 16'h0000, 2'b00);
    pat(TC_HIGH, 16'hffff, 2'b00);
    pat(TC_CLOCK, CLOCK_WORD, 2'b00);
    pat(TC_D215, {CH_D215, CH_D215}, 2'b00);
    pat(TC_K285, {CH_K285, CH_K285}, 2'b11);
    pat(TC_K287, {CH_K287, CH_K287}, 2'b11);
    wr(ADDR_TEST, 8'h0c);
    wr(ADDR_TEST, 8'h11);
    wr(ADDR_TEST, {3'h0, TC_ILA});
    chk(ila_rep, 1'b1);
    wr(ADDR_TEST, {3'h0, TC_RPAT});
    chk({ila_rep, rpat_rep}, 2'b01);
    @(posedge ref_clk);
    m8 <= 1'b0;
    pat(TC_K285, smp, 2'b00);
    @(posedge ref_clk);
    m8 <= 1'b1;
    foreach (walk[i]) begin
      wr(ADDR_TEST, {3'h0, walk[i]});
      @(posedge ref_clk);
      en <= 1'b1;
      repeat (3) @(negedge ref_clk);
      w1 = lane_word;
      @(negedge ref_clk);
      w2 = lane_word;
      if (walk[i] == TC_RAMP) begin
        chk(w1[15:8], 8'(w1[7:0] + 8'h01));
        chk(w2[7:0], 8'(w1[7:0] + 8'h02));
      end else if (walk[i] == TC_TRANS) begin
        chk(w1[15:8], 8'(~w1[7:0]));
        chk(w2[15:8], 8'(w1[15:8] + 8'h01));
      end else begin
        pw = prbs_ref(walk[i]);
        chk(w1 !== w2, 1'b1);
        chk(w1, pw[31:16]);
        chk(w2, pw[15:0]);
      end
      // clock enable low must hold the lane word
      @(posedge ref_clk);
      ce <= 1'b0;
      @(negedge ref_clk);
      w1 = lane_word;
      repeat (2) @(negedge ref_clk);
      chk(lane_word, w1);
      @(posedge ref_clk);
      ce <= 1'b1;
      wr(ADDR_TEST, 8'h00);
      wr(ADDR_DEVNUM, 8'h5a);
      @(posedge ref_clk);
      en <= 1'b0;
    end
    wr(ADDR_DEVNUM, 8'($urandom));
    chk(devnum, lane_align_device_number);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_COMMA, 8'(c));
      chk(fe_char, chr[cc]);
      chk(fe_en, m8);
    end
    @(posedge ref_clk);
    std <= 1'b1;
    wr(ADDR_COMMA, 8'h01);
    wr(ADDR_COMMA, 8'h00);
    @(posedge ref_clk);
    realn <= 1'b1;
    @(posedge ref_clk);
    realn <= 1'b0;
    rl = 1'b1;
    rd(ADDR_STATUS);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS);
    wr(ADDR_STATUS, 8'h10);
    rd(ADDR_STATUS);
    @(posedge ref_clk);
    en <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int n = 0; n < 2; n++) begin
      sref <= 1'b1;
      @(posedge ref_clk);
      sref <= 1'b0;
      al = (n == 0);
      rd(ADDR_STATUS);
      wr(ADDR_STATUS, 8'hef);
      @(posedge ref_clk);
    end
    en <= 1'b0;
    repeat (60) begin
      @(posedge ref_clk);
      {en, std} <= 2'($urandom);
      wr(ADDR_TEST + 10'($urandom_range(4, 0)), 8'($urandom));
      rd(ca);
    end
    finish_test();
  end
endmodule
